// ==== pmsm_pkg.sv ====
/*
 Constants for the serial management master: frame layout, operation codes,
 management clock timing and the controller's state type.
 Assumes a 200 MHz system clock; shared by the design and its bench.
*/
package pmsm_pkg;

    // ***********************************************************
    // frame layout, one bit index per management clock period
    // ***********************************************************
    localparam int unsigned FRAME_BITS = 64;
    localparam logic [5:0] PRE_LAST_IDX = 6'h1F;  // bits 0..31 are preamble ones
    localparam logic [5:0] START_IDX = 6'h20;     // start delimiter, two bits
    localparam logic [5:0] OP_IDX = 6'h22;        // operation code, two bits
    localparam logic [5:0] PHY_IDX = 6'h24;       // phy address, five bits
    localparam logic [5:0] PHY_LAST_IDX = 6'h28;
    localparam logic [5:0] REG_IDX = 6'h29;       // register address, five bits
    localparam logic [5:0] REG_LAST_IDX = 6'h2D;
    localparam logic [5:0] TA_IDX = 6'h2E;        // turnaround, two bits
    localparam logic [5:0] DATA_IDX = 6'h30;      // data, sixteen bits
    localparam logic [5:0] LAST_IDX = 6'h3F;
    localparam logic [6:0] RISES_PER_FRAME = 7'h40;

    // ***********************************************************
    // field codes
    // ***********************************************************
    localparam logic [1:0] START_CODE = 2'h1;     // zero then one
    localparam logic [1:0] OP_READ = 2'h2;
    localparam logic [1:0] OP_WRITE = 2'h1;
    localparam logic [1:0] TA_WRITE = 2'h2;       // one then zero
    localparam logic [15:0] RDATA_RESET = 16'h0000;

    // ***********************************************************
    // timing: management clock half period
    // ***********************************************************
    localparam int unsigned CLK_PERIOD_NS = 5;
    localparam int unsigned MGMT_HALF_NS = 200;   // 2.5 MHz management clock
    // least time, so round up to whole system cycles
    localparam int unsigned HALF_CYC =
        (MGMT_HALF_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam logic [5:0] HALF_LAST = 6'(HALF_CYC - 1);

    typedef enum logic {ST_IDLE, ST_RUN} pmsm_state_t;

endpackage

// ==== pmsm_master.sv ====
/*
 Serial management master: builds 64-bit read and write frames toward the
 PHYs on one shared management clock and data line.
 Assumes the user side is on the same clock as this block; the data pin is
 open with a pull-up outside, its input arrives asynchronously.
*/
// Behaviour
// [RULE_01] With no frame running the data line is released and rests high.
// [RULE_02] Every frame opens with thirty-two one bits, one clock each.
// [RULE_03] A phy answers only after seeing that thirty-two bit preamble.
// [RULE_04] The preamble is followed by start pattern zero then one.
// [RULE_05] Operation code follows: 10 for read, 01 for write.
// [RULE_06] Five-bit phy address follows, most significant bit first.
// [RULE_07] Five-bit register address follows, most significant bit first.
// [RULE_08] Read frames: nobody drives the line in the first turnaround bit.
// [RULE_09] Read frames: the phy drives zero in the second turnaround bit.
// [RULE_10] Write frames: master drives turnaround as one then zero.
// [RULE_11] Sixteen data bits, msb first; line returns to idle afterwards.
// [RULE_12] Two phys share the lines, told apart only by the address field.
// [RULE_13] Data changes after a clock edge; read data sampled on rising edge.
`timescale 1ns/1ps

module pmsm_master
    import pmsm_pkg::*;
(
    input wire logic clock,
    input wire logic srst,
    input wire logic cmd_start,
    input wire logic cmd_read,
    input wire logic [4:0] cmd_phy_addr,
    input wire logic [4:0] cmd_reg_addr,
    input wire logic [15:0] cmd_wdata,
    output logic busy,
    output logic done,
    output logic [15:0] rd_data,
    output logic ta_error,
    output logic mgmt_serial_clock,
    input wire logic mgmt_data_in,
    output logic mgmt_data_out,
    output logic mgmt_data_oe_n
);

    // ***********************************************************
    // frame bit lookup
    // ***********************************************************
    // level to put on the line for a given bit position
    function automatic logic frame_bit(
        input logic [5:0] idx,
        input logic rd,
        input logic [4:0] phy,
        input logic [4:0] regad,
        input logic [15:0] wd
    );
        logic [1:0] op;
        op = rd ? OP_READ : OP_WRITE;
        if (idx <= PRE_LAST_IDX)
            frame_bit = 1'b1; // RULE_02
        else if (idx == START_IDX)
            frame_bit = START_CODE[1]; // RULE_04
        else if (idx == START_IDX + 6'h01)
            frame_bit = START_CODE[0]; // RULE_04
        else if (idx == OP_IDX)
            frame_bit = op[1]; // RULE_05
        else if (idx == OP_IDX + 6'h01)
            frame_bit = op[0]; // RULE_05
        else if (idx <= PHY_LAST_IDX)
            frame_bit = phy[3'(PHY_LAST_IDX - idx)]; // RULE_06
        else if (idx <= REG_LAST_IDX)
            frame_bit = regad[3'(REG_LAST_IDX - idx)]; // RULE_07
        else if (idx == TA_IDX)
            frame_bit = TA_WRITE[1]; // RULE_10
        else if (idx == TA_IDX + 6'h01)
            frame_bit = TA_WRITE[0]; // RULE_10
        else
            frame_bit = wd[4'(LAST_IDX - idx)]; // RULE_11
    endfunction

    // master drives every bit except read turnaround and read data
    function automatic logic frame_drive(input logic [5:0] idx, input logic rd);
        frame_drive = !(rd && idx >= TA_IDX); // RULE_08
    endfunction

    // ***********************************************************
    // state
    // ***********************************************************
    pmsm_state_t state_r;
    logic [5:0] div_r, bit_idx_r;
    logic [4:0] phy_r, reg_r;
    logic [15:0] wdata_r, rshift_r, rdata_r;
    logic [6:0] rise_cnt_r;
    logic mclk_r, is_rd_r, ta_zero_r, dout_r, oe_n_r;
    logic busy_r, done_r, ta_err_r, din_s1_r, din_s2_r;
    // strobes decoded from the state, the start request, the divider, the clock level and the bit position
    logic accept, tick, rise_tick, fall_tick, last_fall;

    assign accept = (state_r == ST_IDLE) && cmd_start;
    assign tick = (state_r == ST_RUN) && (div_r == HALF_LAST);
    assign rise_tick = tick && !mclk_r;
    assign fall_tick = tick && mclk_r;
    assign last_fall = fall_tick && (bit_idx_r == LAST_IDX);

    assign busy = busy_r;
    assign done = done_r;
    assign rd_data = rdata_r;
    assign ta_error = ta_err_r;
    assign mgmt_serial_clock = mclk_r;
    assign mgmt_data_out = dout_r;
    assign mgmt_data_oe_n = oe_n_r;

    // ***********************************************************
    // pin input synchroniser
    // ***********************************************************
    // two flops; only the second one feeds the sampler
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            din_s1_r <= 1'b1;
            din_s2_r <= 1'b1;
        end
        else
        begin
            din_s1_r <= mgmt_data_in;
            din_s2_r <= din_s1_r;
        end
    end

    // ***********************************************************
    // frame sequencer
    // ***********************************************************
    // one frame per accepted command; commands while busy are ignored
    always_ff @(posedge clock)
    begin
        if (srst)
            state_r <= ST_IDLE;
        else
        begin
            case (state_r)
                ST_IDLE:
                    if (accept)
                        state_r <= ST_RUN;
                ST_RUN:
                    if (last_fall)
                        state_r <= ST_IDLE;
                default:
                    state_r <= ST_IDLE;
            endcase
        end
    end

    // half-period divider, restarted per frame so the first bit is full length
    always_ff @(posedge clock)
    begin
        if (srst || accept || tick)
            div_r <= 6'h00;
        else if (state_r == ST_RUN)
            div_r <= div_r + 6'h01;
    end

    // command capture; held for the whole frame
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            is_rd_r <= 1'b0;
            phy_r <= 5'h00;
            reg_r <= 5'h00;
            wdata_r <= 16'h0000;
        end
        else if (accept)
        begin
            is_rd_r <= cmd_read;
            phy_r <= cmd_phy_addr; // RULE_12
            reg_r <= cmd_reg_addr;
            wdata_r <= cmd_wdata;
        end
    end

    // management clock: idles low, rises mid-bit
    always_ff @(posedge clock)
    begin
        if (srst)
            mclk_r <= 1'b0;
        else if (tick)
            mclk_r <= !mclk_r;
    end

    // bit position advances on the falling edge
    always_ff @(posedge clock)
    begin
        if (srst || accept)
            bit_idx_r <= 6'h00;
        else if (fall_tick && !last_fall)
            bit_idx_r <= bit_idx_r + 6'h01;
    end

    // line drive: updated only at start or on a falling edge, so the phy
    // sees a stable bit across each rising edge
    always_ff @(posedge clock)
    begin
        if (srst || last_fall)
        begin
            dout_r <= 1'b1; // RULE_01
            oe_n_r <= 1'b1; // RULE_11
        end
        else if (accept)
        begin
            dout_r <= 1'b1; // RULE_02
            oe_n_r <= 1'b0;
        end
        else if (fall_tick)
        begin
            dout_r <= frame_bit(bit_idx_r + 6'h01, is_rd_r, phy_r, reg_r, wdata_r); // RULE_13
            oe_n_r <= !frame_drive(bit_idx_r + 6'h01, is_rd_r); // RULE_08
        end
    end

    // read sampling on the rising edge of the management clock
    always_ff @(posedge clock)
    begin
        if (srst || accept)
        begin
            rshift_r <= 16'h0000;
            ta_zero_r <= 1'b0;
        end
        else if (rise_tick && is_rd_r)
        begin
            if (bit_idx_r >= DATA_IDX)
                rshift_r <= {rshift_r[14:0], din_s2_r}; // RULE_13
            if (bit_idx_r == TA_IDX + 6'h01)
                ta_zero_r <= !din_s2_r; // RULE_09
        end
    end

    // results; a missing phy leaves the pull-up high in turnaround
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            rdata_r <= RDATA_RESET;
            ta_err_r <= 1'b0;
        end
        else if (last_fall && is_rd_r)
        begin
            rdata_r <= rshift_r; // RULE_11
            ta_err_r <= !ta_zero_r; // RULE_09
        end
        else if (last_fall)
            ta_err_r <= 1'b0;
    end

    // handshake flags toward the user side
    always_ff @(posedge clock)
    begin
        if (srst)
        begin
            busy_r <= 1'b0;
            done_r <= 1'b0;
        end
        else
        begin
            done_r <= last_fall;
            if (accept)
                busy_r <= 1'b1;
            else if (last_fall)
                busy_r <= 1'b0;
        end
    end

    // rising edges per frame, read only by the checks below
    always_ff @(posedge clock)
    begin
        if (srst || accept)
            rise_cnt_r <= 7'h00;
        else if (rise_tick)
            rise_cnt_r <= rise_cnt_r + 7'h01;
    end

    // ***********************************************************
    // checks
    // ***********************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (srst);

    sequence frame_begin;
        accept;
    endsequence

    sequence preamble_head;
        (mgmt_data_out && !mgmt_data_oe_n)[*8];
    endsequence

    idle_release_a: assert property (!busy_r |-> mgmt_data_oe_n && mgmt_data_out) // RULE_01
        else $error("line driven outside a frame");
    preamble_start_a: assert property (frame_begin |=> preamble_head) // RULE_02
        else $error("frame does not open with driven ones");
    preamble_ones_a: assert property (busy_r && bit_idx_r <= PRE_LAST_IDX
        |-> mgmt_data_out && !mgmt_data_oe_n) // RULE_02
        else $error("preamble bit not a driven one");
    start_pattern_a: assert property (busy_r && fall_tick && bit_idx_r == PRE_LAST_IDX
        |=> !mgmt_data_out && !mgmt_data_oe_n) // RULE_04
        else $error("start delimiter first bit not zero");
    start_second_a: assert property (busy_r && bit_idx_r == START_IDX + 6'h01
        |-> mgmt_data_out) // RULE_04
        else $error("start delimiter second bit not one");
    opcode_bits_a: assert property (busy_r && bit_idx_r == OP_IDX
        |-> mgmt_data_out == is_rd_r && !mgmt_data_oe_n) // RULE_05
        else $error("operation code first bit wrong");
    opcode_second_a: assert property (busy_r && bit_idx_r == OP_IDX + 6'h01
        |-> mgmt_data_out == !is_rd_r) // RULE_05
        else $error("operation code second bit wrong");
    phy_msb_a: assert property (busy_r && bit_idx_r == PHY_IDX
        |-> mgmt_data_out == phy_r[4]) // RULE_06 RULE_12
        else $error("phy address not msb first");
    reg_lsb_a: assert property (busy_r && bit_idx_r == REG_LAST_IDX
        |-> mgmt_data_out == reg_r[0]) // RULE_07
        else $error("register address last bit wrong");
    read_release_a: assert property (busy_r && is_rd_r && bit_idx_r >= TA_IDX
        |-> mgmt_data_oe_n) // RULE_08
        else $error("master drives during read turnaround");
    write_turn_a: assert property (busy_r && !is_rd_r && bit_idx_r == TA_IDX
        ##0 fall_tick |=> !mgmt_data_out && !mgmt_data_oe_n) // RULE_10
        else $error("write turnaround not one then zero");
    write_data_a: assert property (busy_r && !is_rd_r && bit_idx_r == DATA_IDX
        |-> mgmt_data_out == wdata_r[15]) // RULE_11
        else $error("write data not msb first");
    frame_len_a: assert property (done_r |-> rise_cnt_r == RISES_PER_FRAME
        && mgmt_data_oe_n && !busy_r) // RULE_11
        else $error("frame length not sixty-four clocks");
    edge_stable_a: assert property (rise_tick |=> $stable(mgmt_data_out)
        && $stable(mgmt_data_oe_n)) // RULE_13
        else $error("data changed on a rising edge");
    change_low_a: assert property ($changed(mgmt_data_out) && busy_r
        |-> !mgmt_serial_clock) // RULE_13
        else $error("data changed while clock high");

endmodule

// ==== pmsm_phy_model.sv ====
/*
 Behavioural model of one PHY on the shared management bus.
 Assumes the bench resolves the data line (pull-up when nobody drives)
 and feeds it back on line_in.
*/
`timescale 1ns/1ps

module pmsm_phy_model #(
    parameter logic [4:0] MY_ADDR = 5'h03,
    parameter logic [4:0] BAD_REG = 5'h1F
)(
    input wire logic mgmt_serial_clock,
    input wire logic line_in,
    output logic drive_en,
    output logic drive_val
);
    logic [15:0] mem [32];
    logic [12:0] hdr;
    logic [15:0] sh;
    int ones = 0;
    int pos = 0;
    int talk = 0;

    // register contents seeded from own address so the two phys differ
    initial
    begin
        drive_en = 1'b0;
        drive_val = 1'b1;
        for (int r = 0; r < 32; r++)
            mem[r] = {3'h5, MY_ADDR, 3'h2, 5'(r)};
    end

    // *********************************************************
    // receive side: sample on the rising management clock
    // *********************************************************
    always @(posedge mgmt_serial_clock)
    begin
        if (pos == 0)
        begin
            // a zero only opens a frame after a full preamble
            if (line_in !== 1'b1 && ones >= 32) pos = 1;
            ones = (line_in === 1'b1) ? ones + 1 : 0;
        end
        else
        begin
            if (pos <= 13) hdr = {hdr[11:0], line_in};
            else sh = {sh[14:0], line_in};
            // only our own address answers on the shared lines
            if (pos == 13) talk = (hdr[11:10] == 2'h2 && hdr[9:5] == MY_ADDR) ? 1 : 0;
            if (pos == 31 && hdr[11:10] == 2'h1 && hdr[9:5] == MY_ADDR) mem[hdr[4:0]] = sh;
            pos = (pos == 31) ? 0 : pos + 1;
        end
    end

    // drive at the falling edge so the first turnaround bit stays undriven
    always @(negedge mgmt_serial_clock)
    begin
        if (talk > 0)
        begin
            talk = talk + 1;
            drive_en = (talk >= 3 && talk <= 19);
            // register BAD_REG answers with a broken turnaround on purpose
            if (talk == 3)
                drive_val = (hdr[4:0] == BAD_REG);
            else
                drive_val = mem[hdr[4:0]][4'(19 - talk)];
            if (talk > 19) talk = 0;
        end
    end
endmodule

// ==== tb_top.sv ====
/*
 Self-checking bench for the serial management master with two phy models.
 Assumes the package constants and a 200 MHz clock; the pull-up is modelled
 in the wire resolution below.
*/
`timescale 1ns/1ps

module tb_top
    import pmsm_pkg::*;
;
    typedef struct packed {
        logic [63:0] bits;
        logic [63:0] oe;
        logic [15:0] rd;
        logic ta;
    } pmsm_exp_t;

    localparam logic [4:0] PHY_A = 5'h03;
    localparam logic [4:0] PHY_B = 5'h1C;
    localparam logic [4:0] BAD_REG = 5'h1F;

    logic clock = 1'b0;
    logic srst, cmd_start, cmd_read, busy, done, ta_error;
    logic [4:0] cmd_phy_addr, cmd_reg_addr;
    logic [15:0] cmd_wdata, rd_data, last_rd;
    logic mgmt_serial_clock, mdio_line, mgmt_data_out, mgmt_data_oe_n;
    logic a_en, a_val, b_en, b_val;
    logic [63:0] seen_bits, seen_oe;
    logic [15:0] shadow [32][32];
    logic [31:0] seed = 32'h7BF71086;
    int rises = 0;
    int error_cnt = 0;
    int checked = 0;
    pmsm_exp_t exp_q[$];
    pmsm_exp_t mon_e;

    always #2.5 clock = ~clock;

    // open-drain line: master, then either phy, else the pull-up
    assign mdio_line = !mgmt_data_oe_n ? mgmt_data_out : (a_en ? a_val : (b_en ? b_val : 1'b1));

    pmsm_master dut_u (.clock(clock), .srst(srst), .cmd_start(cmd_start), .cmd_read(cmd_read),
        .cmd_phy_addr(cmd_phy_addr), .cmd_reg_addr(cmd_reg_addr), .cmd_wdata(cmd_wdata),
        .busy(busy), .done(done), .rd_data(rd_data), .ta_error(ta_error),
        .mgmt_serial_clock(mgmt_serial_clock), .mgmt_data_in(mdio_line),
        .mgmt_data_out(mgmt_data_out), .mgmt_data_oe_n(mgmt_data_oe_n));
    pmsm_phy_model #(.MY_ADDR(PHY_A), .BAD_REG(BAD_REG)) phy_a_u (
        .mgmt_serial_clock(mgmt_serial_clock), .line_in(mdio_line),
        .drive_en(a_en), .drive_val(a_val));
    pmsm_phy_model #(.MY_ADDR(PHY_B), .BAD_REG(BAD_REG)) phy_b_u (
        .mgmt_serial_clock(mgmt_serial_clock), .line_in(mdio_line),
        .drive_en(b_en), .drive_val(b_val));

    // *********************************************************
    // helpers
    // *********************************************************
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction

    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        checked++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("ERROR at %0t ns: seen %h expected %h", $time, got, exp);
        end
    endtask

    task automatic complete_run;
        $display("comparisons %0d mismatches %0d", checked, error_cnt);
        if (error_cnt == 0 && checked > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // request held high while busy, so refused requests are exercised too
    task automatic send(input logic rd, input logic [4:0] pa, input logic [4:0] ra,
                        input logic [15:0] wd);
        pmsm_exp_t e;
        logic [15:0] v;
        logic here;
        logic t;
        cmd_read <= rd;
        cmd_phy_addr <= pa;
        cmd_reg_addr <= ra;
        cmd_wdata <= wd;
        cmd_start <= 1'b1;
        do @(posedge clock); while (busy !== 1'b0);
        here = (pa == PHY_A) || (pa == PHY_B);
        t = rd && (!here || ra == BAD_REG);
        v = rd ? (here ? shadow[pa][ra] : 16'hFFFF) : last_rd;
        if (!rd) shadow[pa][ra] = wd;
        if (rd) last_rd = v;
        e.bits = {32'hFFFFFFFF, START_CODE, rd ? OP_READ : OP_WRITE, pa, ra,
                  rd ? {1'b1, t} : TA_WRITE, rd ? v : wd};
        e.oe = rd ? {46'h0, 18'h3FFFF} : 64'h0;
        e.rd = v;
        e.ta = t;
        exp_q.push_back(e);
    endtask

    // *********************************************************
    // observers
    // *********************************************************
    // wire bits as a phy would take them, on the rising edge
    always @(posedge mgmt_serial_clock)
    begin
        seen_bits = {seen_bits[62:0], mdio_line};
        seen_oe = {seen_oe[62:0], mgmt_data_oe_n};
        rises++;
    end

    // done edge: oldest note against frame on the wire and user outputs
    always @(posedge clock)
    begin
        if (done === 1'b1)
        begin
            if (exp_q.size() == 0)
                check(64'h0, 64'h1);
            else
            begin
                mon_e = exp_q.pop_front();
                check(seen_bits, mon_e.bits);
                check(64'(seen_bits[22:0]), 64'(mon_e.bits[22:0]));
                check(seen_oe, mon_e.oe);
                check(64'(rises), 64'h40);
                check(64'({rd_data, ta_error}), 64'({mon_e.rd, mon_e.ta}));
                check(64'({mgmt_serial_clock, mgmt_data_oe_n, mgmt_data_out}), 64'h3);
                check(64'(busy), 64'h0);
            end
            rises = 0;
        end
    end

    // hang guard sized for fifteen frames of 5120 cycles
    initial
    begin
        repeat (90000) @(posedge clock);
        error_cnt++;
        complete_run();
    end

    // *********************************************************
    // main sequence
    // *********************************************************
    initial
    begin
        srst <= 1'b1;
        cmd_start <= 1'b0;
        cmd_read <= 1'b0;
        cmd_phy_addr <= 5'h00;
        cmd_reg_addr <= 5'h00;
        cmd_wdata <= 16'h0000;
        last_rd = 16'h0000;
        for (int p = 0; p < 32; p++)
            for (int r = 0; r < 32; r++)
                shadow[p][r] = {3'h5, 5'(p), 3'h2, 5'(r)};
        repeat (6) @(posedge clock);
        check(64'({busy, done, rd_data, ta_error, mgmt_serial_clock, mgmt_data_out,
                   mgmt_data_oe_n}), 64'h3);
        srst <= 1'b0;
        rises = 0;
        // both phys, same register, then the broken turnaround and an absent phy
        send(1'b0, PHY_A, 5'h05, 16'h1234);
        send(1'b0, PHY_B, 5'h05, 16'hBEEF);
        send(1'b0, PHY_A, BAD_REG, 16'h8001);
        send(1'b1, PHY_A, 5'h05, 16'h0000);
        send(1'b1, PHY_B, 5'h05, 16'h0000);
        send(1'b1, PHY_A, BAD_REG, 16'h0000);
        send(1'b1, 5'h00, 5'h0A, 16'h0000);
        for (int i = 0; i < 8; i++)
        begin
            seed = xs(seed);
            send(seed[0], (seed[2:1] == 2'h0) ? seed[7:3] : (seed[1] ? PHY_A : PHY_B),
                 seed[12:8], seed[31:16]);
        end
        cmd_start <= 1'b0;
        while (exp_q.size() != 0) @(posedge clock);
        repeat (4) @(posedge clock);
        complete_run();
    end
endmodule
